// ==== dsa_pkg.sv ====
// constants and types for the data space byte/word access path
package dsa_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int WREG_N = 16;
    localparam int WIDX_W = 4;
    localparam int NEAR_FIELD_W = 13;
    localparam logic [15:0] SFR_LAST = 16'h0FFF;
    localparam logic [15:0] NEAR_LAST = 16'h1FFF;
    localparam logic [15:0] RAM_FIRST = 16'h1000;
    localparam logic [15:0] RAM_LAST = 16'hCFFF;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] WREG_RST = 16'h0000;
    localparam logic [15:0] FAULT_RST = 16'h0000;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_LOAD = 3'b001,
        OP_STORE = 3'b010,
        OP_SIGN_EXT = 3'b011,
        OP_ZERO_EXT = 3'b100
    } op_kind_t;

    typedef enum logic [1:0] {
        AM_NEAR13 = 2'b00,
        AM_ABS16 = 2'b01,
        AM_INDIRECT = 2'b10,
        AM_POSTINC = 2'b11
    } addr_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_LOAD = 2'b10,
        ST_TRAP = 2'b11
    } state_t;
endpackage

// ==== lane_if.sv ====
// signals between the access sequencer and a byte-lane steering unit
interface lane_if;
    import dsa_pkg::*;
    logic [DATA_W-1:0] byte_addr;
    logic is_byte;
    logic is_write;
    logic enable;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rword;
    logic [DATA_W-1:0] wword;
    logic [DATA_W-1:0] rdata;
    logic strobe_lo;
    logic strobe_hi;
    logic misaligned;
    modport steer (
        input byte_addr, is_byte, is_write, enable, wdata, rword,
        output wword, rdata, strobe_lo, strobe_hi, misaligned
    );
    modport ctrl (
        output byte_addr, is_byte, is_write, enable, wdata, rword,
        input wword, rdata, strobe_lo, strobe_hi, misaligned
    );
endinterface

// ==== lane_steer.sv ====
// byte-lane steering: alignment check, write strobes, lane placement
module lane_steer
    import dsa_pkg::*;
(
    // sequencer side
    lane_if.steer lp
);
    wire odd = lp.byte_addr[0];
    wire [BYTE_W-1:0] lo_byte = lp.rword[BYTE_W-1:0];
    wire [BYTE_W-1:0] hi_byte = lp.rword[DATA_W-1:BYTE_W];
    wire [BYTE_W-1:0] pick = odd ? hi_byte : lo_byte;
    wire wr_ok = lp.enable && lp.is_write && !lp.misaligned;

    // word access at an odd byte address
    assign lp.misaligned = !lp.is_byte && odd;
    // even byte is the low lane, odd byte the high lane
    assign lp.strobe_lo = wr_ok && (!lp.is_byte || !odd);
    assign lp.strobe_hi = wr_ok && (!lp.is_byte || odd);
    // a byte is copied to both lanes; the strobe decides which one lands
    assign lp.wword = lp.is_byte ? {lp.wdata[BYTE_W-1:0], lp.wdata[BYTE_W-1:0]} : lp.wdata;
    assign lp.rdata = lp.is_byte ? {{BYTE_W{1'b0}}, pick} : lp.rword;
endmodule

// ==== data_space_access.sv ====
// data space access path: addressing, byte/word lanes, traps, working registers
// What this block does
// - post-increment pointer steps by 1 for bytes, 2 for words
// - byte read fetches the word, picks a byte by bit 0, puts it low
// - two byte lanes share the word address but have separate write strobes
// - word access at an odd address raises the address error trap
// - misaligned read still completes before the trap is taken
// - misaligned write executes but nothing is written
// - after a misaligned access the trap is taken; post-increment and read writeback still happen
// - byte loads land in the register low byte, high byte kept
// - sign extension copies bit 7 into the upper byte
// - zero extension clears the upper byte of a register
// - byte addresses 0x0000 to 0x0FFF form the special register region
// - unused special register addresses read as zero
// - near region 0x0000 to 0x1FFF reached by a 13-bit direct field
// - move instructions reach the whole space by a 16-bit direct field
// - any location reachable indirectly through a working register pointer
// - even byte address is the low byte, odd address the high byte
// - addresses outside registers and RAM read as all zero
module data_space_access
    import dsa_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // operation request from the pipeline
    input wire logic op_valid,
    output logic op_ready,
    input wire op_kind_t op_kind,
    input wire logic op_byte,
    input wire addr_mode_t op_mode,
    input wire logic [WIDX_W-1:0] op_ptr_idx,
    input wire logic [WIDX_W-1:0] op_reg_idx,
    input wire logic [DATA_W-1:0] op_abs_addr,
    // working register port of the pipeline
    input wire logic core_wr_en,
    input wire logic [WIDX_W-1:0] core_wr_idx,
    input wire logic [DATA_W-1:0] core_wr_data,
    input wire logic [WIDX_W-1:0] core_rd_idx,
    output logic [DATA_W-1:0] core_rd_data,
    // data memory and special register port
    output logic [DATA_W-2:0] mem_word_addr,
    output logic mem_rd,
    output logic mem_we_lo,
    output logic mem_we_hi,
    output logic [DATA_W-1:0] mem_wdata,
    output logic mem_sfr_sel,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic sfr_hit,
    // address error trap
    output logic addr_error_trap,
    output logic [DATA_W-1:0] fault_addr
);
    state_t state_q, state_d;
    logic [DATA_W-1:0] wreg_q [WREG_N];
    logic [DATA_W-1:0] addr_q;
    logic byte_q, load_q, fault_q, sfr_q, impl_q;
    logic [WIDX_W-1:0] dst_q;
    logic [DATA_W-2:0] mem_addr_q;
    logic mem_rd_q, we_lo_q, we_hi_q, sfr_sel_q;
    logic [DATA_W-1:0] mem_wdata_q, fault_addr_q, rd_data_q;

    lane_if li_issue();
    lane_if li_ret();
    lane_steer u_issue (.lp(li_issue.steer));
    lane_steer u_ret (.lp(li_ret.steer));

    // operand selection
    wire [DATA_W-1:0] ptr_val = wreg_q[op_ptr_idx];
    wire [DATA_W-1:0] src_val = wreg_q[op_reg_idx];
    wire [DATA_W-1:0] near_ea = {{(DATA_W-NEAR_FIELD_W){1'b0}},
                                 op_abs_addr[NEAR_FIELD_W-1:0]};
    wire use_ptr = (op_mode == AM_INDIRECT) || (op_mode == AM_POSTINC);
    wire [DATA_W-1:0] ea = use_ptr ? ptr_val :
                           (op_mode == AM_ABS16) ? op_abs_addr : near_ea;
    wire [DATA_W-1:0] step = op_byte ? STEP_BYTE : STEP_WORD;
    wire [DATA_W-1:0] post_ptr = ptr_val + step;

    // request decode
    wire is_load = (op_kind == OP_LOAD);
    wire is_store = (op_kind == OP_STORE);
    wire is_mem = is_load || is_store;
    wire is_ext = (op_kind == OP_SIGN_EXT) || (op_kind == OP_ZERO_EXT);
    wire accept = op_valid && (state_q == ST_IDLE);
    wire mem_go = accept && is_mem;

    // region decode
    wire in_sfr = (ea <= SFR_LAST);
    wire in_ram = (ea >= RAM_FIRST) && (ea <= RAM_LAST);
    wire implemented = in_sfr || in_ram;

    // issue-side lane steering
    assign li_issue.byte_addr = ea;
    assign li_issue.is_byte = op_byte;
    assign li_issue.is_write = is_store;
    assign li_issue.enable = mem_go;
    assign li_issue.wdata = src_val;
    assign li_issue.rword = '0;

    // return data: unclaimed special registers and holes read as zero
    wire [DATA_W-1:0] ret_word = !impl_q ? '0 :
                                 (sfr_q && !sfr_hit) ? '0 : mem_rdata;
    assign li_ret.byte_addr = addr_q;
    assign li_ret.is_byte = byte_q;
    assign li_ret.is_write = 1'b0;
    assign li_ret.enable = 1'b0;
    assign li_ret.wdata = '0;
    assign li_ret.rword = ret_word;

    // register writeback
    wire [DATA_W-1:0] dst_old = wreg_q[dst_q];
    wire [BYTE_W-1:0] dst_old_hi = dst_old[DATA_W-1:BYTE_W];
    wire [DATA_W-1:0] load_val = byte_q ?
        {dst_old_hi, li_ret.rdata[BYTE_W-1:0]} : li_ret.rdata;
    wire src_sign = src_val[BYTE_W-1];
    wire [BYTE_W-1:0] src_low = src_val[BYTE_W-1:0];
    wire [DATA_W-1:0] sext_val = {{BYTE_W{src_sign}}, src_low};
    wire [DATA_W-1:0] zext_val = {{BYTE_W{1'b0}}, src_low};
    wire [DATA_W-1:0] ext_val = (op_kind == OP_SIGN_EXT) ? sext_val : zext_val;
    wire in_load = (state_q == ST_LOAD);
    // a faulting read still completes its register update
    wire wb_en = in_load || (accept && is_ext);
    wire [WIDX_W-1:0] wb_idx = in_load ? dst_q : op_reg_idx;
    wire [DATA_W-1:0] wb_data = in_load ? load_val : ext_val;
    wire ptr_en = mem_go && (op_mode == AM_POSTINC);

    // outputs
    assign op_ready = (state_q == ST_IDLE);
    assign core_rd_data = rd_data_q;
    assign mem_word_addr = mem_addr_q;
    assign mem_rd = mem_rd_q;
    assign mem_we_lo = we_lo_q;
    assign mem_we_hi = we_hi_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_sfr_sel = sfr_sel_q;
    assign addr_error_trap = (state_q == ST_TRAP);
    assign fault_addr = fault_addr_q;

    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (mem_go) state_d = ST_ACCESS;
            ST_ACCESS: state_d = load_q ? ST_LOAD : (fault_q ? ST_TRAP : ST_IDLE);
            ST_LOAD: state_d = fault_q ? ST_TRAP : ST_IDLE;
            ST_TRAP: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // access context latched when the request is taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_q <= '0;
            byte_q <= 1'b0;
            load_q <= 1'b0;
            fault_q <= 1'b0;
            sfr_q <= 1'b0;
            impl_q <= 1'b0;
            dst_q <= '0;
        end else if (mem_go) begin
            addr_q <= ea;
            byte_q <= op_byte;
            load_q <= is_load;
            fault_q <= li_issue.misaligned;
            sfr_q <= in_sfr;
            impl_q <= implemented;
            dst_q <= op_reg_idx;
        end
    end

    // memory port; read, strobes and select held for the access cycle only, address and data kept
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_addr_q <= '0;
            mem_rd_q <= 1'b0;
            we_lo_q <= 1'b0;
            we_hi_q <= 1'b0;
            mem_wdata_q <= '0;
            sfr_sel_q <= 1'b0;
        end else begin
            mem_addr_q <= mem_go ? ea[DATA_W-1:1] : mem_addr_q;
            mem_rd_q <= mem_go && is_load && implemented;
            we_lo_q <= li_issue.strobe_lo && implemented;
            we_hi_q <= li_issue.strobe_hi && implemented;
            mem_wdata_q <= mem_go ? li_issue.wword : mem_wdata_q;
            sfr_sel_q <= mem_go && in_sfr;
        end
    end

    // faulting address kept for the trap handler
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_addr_q <= FAULT_RST;
        end else if (mem_go && li_issue.misaligned) begin
            fault_addr_q <= ea;
        end
    end

    // working registers; own updates win over the pipeline port
    always_ff @(posedge clk) begin
        for (int i = 0; i < WREG_N; i++) begin
            if (!rst_n) begin
                wreg_q[i] <= WREG_RST;
            end else if (wb_en && wb_idx == WIDX_W'(i)) begin
                wreg_q[i] <= wb_data;
            end else if (ptr_en && op_ptr_idx == WIDX_W'(i)) begin
                wreg_q[i] <= post_ptr;
            end else if (core_wr_en && core_wr_idx == WIDX_W'(i)) begin
                wreg_q[i] <= core_wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= wreg_q[core_rd_idx];
        end
    end

    // checks
    chk_step_scale: assert property (@(posedge clk) disable iff (!rst_n)
        ptr_en |=> wreg_q[$past(op_ptr_idx)] ==
            $past(ptr_val) + ($past(op_byte) ? 16'h0001 : 16'h0002))
        else $error("post-increment step does not match access size");

    chk_byte_place: assert property (@(posedge clk) disable iff (!rst_n)
        (in_load && byte_q) |-> li_ret.rdata ==
            {8'h00, addr_q[0] ? ret_word[15:8] : ret_word[7:0]})
        else $error("byte read not placed on low byte");

    chk_lane_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && is_store && implemented && !li_issue.misaligned) |=>
            (mem_we_lo == (!$past(op_byte) || !$past(ea[0]))) &&
            (mem_we_hi == (!$past(op_byte) || $past(ea[0]))))
        else $error("write strobes do not match lane");

    chk_misalign_trap: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && !op_byte && ea[0]) |-> ##[2:3] addr_error_trap)
        else $error("misaligned word access raised no trap");

    chk_read_finish: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && is_load && !op_byte && ea[0]) |=> ##1 in_load ##1 addr_error_trap)
        else $error("misaligned read did not complete before trap");

    chk_write_block: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && is_store && !op_byte && ea[0]) |=> !mem_we_lo && !mem_we_hi ##1
            addr_error_trap)
        else $error("misaligned write reached memory");

    chk_trap_addr: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(addr_error_trap) |-> fault_addr[0] && fault_addr == addr_q)
        else $error("trap without faulting address");

    chk_byte_load: assert property (@(posedge clk) disable iff (!rst_n)
        (in_load && byte_q) |=> wreg_q[$past(dst_q)][15:8] == $past(dst_old_hi))
        else $error("byte load changed high byte");

    chk_sign_ext: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && op_kind == OP_SIGN_EXT) |=>
            wreg_q[$past(op_reg_idx)] == {{8{$past(src_sign)}}, $past(src_low)})
        else $error("sign extension wrong");

    chk_zero_ext: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && op_kind == OP_ZERO_EXT) |=>
            wreg_q[$past(op_reg_idx)] == {8'h00, $past(src_low)})
        else $error("zero extension wrong");

    chk_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (in_load && sfr_q && !sfr_hit) |=> wreg_q[$past(dst_q)][7:0] == 8'h00)
        else $error("unclaimed special register read not zero");

    chk_near_range: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && op_mode == AM_NEAR13) |=>
            mem_word_addr == ($past(op_abs_addr[15:1]) & NEAR_LAST[15:1]))
        else $error("near address beyond near region");

    chk_word_lanes: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && is_store && !op_byte && !ea[0] && implemented) |=>
            mem_we_lo && mem_we_hi && mem_wdata == $past(src_val))
        else $error("aligned word store not written whole");

    chk_byte_copy: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && is_store && op_byte) |=> mem_wdata == {2{$past(src_val[7:0])}})
        else $error("byte store not copied to both lanes");

    chk_sfr_select: assert property (@(posedge clk) disable iff (!rst_n)
        mem_go |=> mem_sfr_sel == ($past(ea) <= 16'h0FFF))
        else $error("special register select wrong");

    chk_hole_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_go && !implemented) |=> !mem_rd && !mem_we_lo && !mem_we_hi ##1
            (!load_q || ret_word == 16'h0000))
        else $error("access outside implemented area not zero");
endmodule

// ==== mem_model.sv ====
// data memory and special register model answering the access path
module mem_model
    import dsa_pkg::*;
(
    // clock
    input wire logic clk,
    // access from the block
    input wire logic [DATA_W-2:0] word_addr,
    input wire logic rd,
    input wire logic we_lo,
    input wire logic we_hi,
    input wire logic [DATA_W-1:0] wdata,
    // read answer, one cycle after rd
    output logic [DATA_W-1:0] rdata,
    output logic hit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [0:32767];
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 16'(i) ^ 16'hA55A;
        end
        rdata = 16'h0000;
        hit = 1'b0;
    end
    // lanes share one word address but each has its own strobe
    always @(posedge clk) begin
        if (we_lo) begin
            mem[word_addr][7:0] <= wdata[7:0];
        end
        if (we_hi) begin
            mem[word_addr][15:8] <= wdata[15:8];
        end
        // only the first words of the register region are populated
        if (rd) begin
            rdata <= mem[word_addr];
            hit <= (word_addr < 15'h0080);
        end else begin
            rdata <= ~rdata;
            hit <= ~hit;
        end
    end
endmodule

// ==== data_space_byte_word_access_tb_top.sv ====
// self-checking bench for the data space access path
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module data_space_byte_word_access_tb_top
    import dsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    logic op_ready;
    op_kind_t op_kind = OP_NONE;
    logic op_byte = 1'b0;
    addr_mode_t op_mode = AM_NEAR13;
    logic [WIDX_W-1:0] op_ptr_idx = 4'h0;
    logic [WIDX_W-1:0] op_reg_idx = 4'h0;
    logic [DATA_W-1:0] op_abs_addr = 16'h0000;
    logic core_wr_en = 1'b0;
    logic [WIDX_W-1:0] core_wr_idx = 4'h0;
    logic [DATA_W-1:0] core_wr_data = 16'h0000;
    logic [WIDX_W-1:0] core_rd_idx = 4'h0;
    logic [DATA_W-1:0] core_rd_data;
    logic [DATA_W-2:0] mem_word_addr;
    logic mem_rd, mem_we_lo, mem_we_hi, mem_sfr_sel, sfr_hit, addr_error_trap;
    logic [DATA_W-1:0] mem_wdata, mem_rdata, fault_addr;
    int fail_count = 0;
    int tests_run = 0;
    int n_lo = 0, n_hi = 0, n_sfr = 0, n_trap = 0;

    data_space_access u_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
        .op_ready(op_ready), .op_kind(op_kind), .op_byte(op_byte), .op_mode(op_mode),
        .op_ptr_idx(op_ptr_idx), .op_reg_idx(op_reg_idx), .op_abs_addr(op_abs_addr),
        .core_wr_en(core_wr_en), .core_wr_idx(core_wr_idx), .core_wr_data(core_wr_data),
        .core_rd_idx(core_rd_idx), .core_rd_data(core_rd_data),
        .mem_word_addr(mem_word_addr), .mem_rd(mem_rd), .mem_we_lo(mem_we_lo),
        .mem_we_hi(mem_we_hi), .mem_wdata(mem_wdata), .mem_sfr_sel(mem_sfr_sel),
        .mem_rdata(mem_rdata), .sfr_hit(sfr_hit), .addr_error_trap(addr_error_trap),
        .fault_addr(fault_addr));
    mem_model u_mem (.clk(clk), .word_addr(mem_word_addr), .rd(mem_rd),
        .we_lo(mem_we_lo), .we_hi(mem_we_hi), .wdata(mem_wdata), .rdata(mem_rdata),
        .hit(sfr_hit));

    initial begin
        forever #5 clk = ~clk;
    end
    // strobes and the trap are one-cycle pulses, counted mid-cycle
    always @(negedge clk) begin
        if (mem_we_lo === 1'b1) n_lo++;
        if (mem_we_hi === 1'b1) n_hi++;
        if (mem_sfr_sel === 1'b1) n_sfr++;
        if (addr_error_trap === 1'b1) n_trap++;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clk);
        while (op_ready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                wrap_up();
            end
            @(negedge clk);
        end
    endtask
    task automatic op(op_kind_t k, logic b, addr_mode_t m, logic [WIDX_W-1:0] p,
        logic [WIDX_W-1:0] r, logic [DATA_W-1:0] a);
        wait_idle();
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_byte <= b;
        op_mode <= m;
        op_ptr_idx <= p;
        op_reg_idx <= r;
        op_abs_addr <= a;
        @(posedge clk);
        op_valid <= 1'b0;
        wait_idle();
    endtask
    task automatic set_reg(logic [WIDX_W-1:0] i, logic [DATA_W-1:0] d);
        @(posedge clk);
        core_wr_en <= 1'b1;
        core_wr_idx <= i;
        core_wr_data <= d;
        @(posedge clk);
        core_wr_en <= 1'b0;
    endtask
    task automatic chk_reg(logic [WIDX_W-1:0] i, logic [DATA_W-1:0] e);
        @(posedge clk);
        core_rd_idx <= i;
        @(posedge clk);
        @(negedge clk);
        `CHK(core_rd_data, e)
    endtask

    task automatic test_reset();
        @(negedge clk);
        `CHK(op_ready, 1'b1)
        `CHK(addr_error_trap, 1'b0)
        `CHK(fault_addr, FAULT_RST)
        chk_reg(4'h2, WREG_RST);
        $display("test reset done");
    endtask
    task automatic test_store();
        set_reg(4'h1, 16'h1100);
        set_reg(4'h2, 16'h12AB);
        op(OP_STORE, 1'b1, AM_POSTINC, 4'h1, 4'h2, 16'h0000);
        `CHK(n_lo, 1)
        `CHK(n_hi, 0)
        `CHK(u_mem.mem[15'h0880], 16'hADAB)
        chk_reg(4'h1, 16'h1101);
        op(OP_STORE, 1'b1, AM_POSTINC, 4'h1, 4'h2, 16'h0000);
        `CHK(n_hi, 1)
        `CHK(u_mem.mem[15'h0880], 16'hABAB)
        op(OP_STORE, 1'b0, AM_POSTINC, 4'h1, 4'h2, 16'h0000);
        `CHK(n_lo + n_hi, 4)
        `CHK(u_mem.mem[15'h0881], 16'h12AB)
        chk_reg(4'h1, 16'h1104);
        $display("test store done");
    endtask
    task automatic test_load();
        set_reg(4'h3, 16'h7700);
        set_reg(4'h4, 16'h1234);
        set_reg(4'h5, 16'h2002);
        op(OP_LOAD, 1'b1, AM_ABS16, 4'h0, 4'h3, 16'h2001);
        chk_reg(4'h3, 16'h77B5);
        op(OP_LOAD, 1'b1, AM_INDIRECT, 4'h5, 4'h4, 16'h0000);
        chk_reg(4'h4, 16'h125B);
        chk_reg(4'h5, 16'h2002);
        op(OP_SIGN_EXT, 1'b0, AM_NEAR13, 4'h0, 4'h3, 16'h0000);
        chk_reg(4'h3, 16'hFFB5);
        op(OP_ZERO_EXT, 1'b0, AM_NEAR13, 4'h0, 4'h4, 16'h0000);
        chk_reg(4'h4, 16'h005B);
        op(OP_NONE, 1'b0, AM_POSTINC, 4'h5, 4'h4, 16'h0000);
        chk_reg(4'h5, 16'h2002);
        op(OP_LOAD, 1'b0, AM_NEAR13, 4'h0, 4'h6, 16'hF100);
        chk_reg(4'h6, 16'hABAB);
        $display("test load done");
    endtask
    task automatic test_fault();
        set_reg(4'h1, 16'h3001);
        op(OP_STORE, 1'b0, AM_POSTINC, 4'h1, 4'h2, 16'h0000);
        `CHK(n_lo + n_hi, 4)
        `CHK(u_mem.mem[15'h1800], 16'hBD5A)
        `CHK(n_trap, 1)
        `CHK(fault_addr, 16'h3001)
        chk_reg(4'h1, 16'h3003);
        op(OP_LOAD, 1'b0, AM_POSTINC, 4'h1, 4'h5, 16'h0000);
        chk_reg(4'h5, 16'hBD5B);
        `CHK(n_trap, 2)
        `CHK(fault_addr, 16'h3003)
        $display("test fault done");
    endtask
    task automatic test_region();
        op(OP_LOAD, 1'b0, AM_ABS16, 4'h0, 4'h7, 16'h0010);
        chk_reg(4'h7, 16'hA552);
        `CHK(n_sfr, 1)
        op(OP_LOAD, 1'b0, AM_ABS16, 4'h0, 4'h7, 16'h0800);
        chk_reg(4'h7, 16'h0000);
        set_reg(4'h7, 16'h1111);
        op(OP_LOAD, 1'b0, AM_ABS16, 4'h0, 4'h7, 16'hE000);
        chk_reg(4'h7, 16'h0000);
        op(OP_STORE, 1'b0, AM_ABS16, 4'h0, 4'h2, 16'hE000);
        `CHK(n_lo, 2)
        op(OP_STORE, 1'b0, AM_ABS16, 4'h0, 4'h2, 16'h0FFE);
        `CHK(n_sfr, 3)
        `CHK(u_mem.mem[15'h07FF], 16'h12AB)
        op(OP_STORE, 1'b0, AM_ABS16, 4'h0, 4'h2, 16'h1000);
        `CHK(n_sfr, 3)
        `CHK(u_mem.mem[15'h0800], 16'h12AB)
        $display("test region done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_store();
        test_load();
        test_fault();
        test_region();
        wrap_up();
    end
endmodule
